// ==== gpc_pad_ctl.sv ====
// per-pin pad steering: output enables, input connect, pulls, buffer level
module gpc_pad_ctl #(
  parameter int NUM_IO = 3
) (
  input wire logic [NUM_IO-1:0] dir,            // 1 = output
  input wire logic [NUM_IO:0] conn,             // 1 = pin connected
  input wire logic [NUM_IO:0] pull,             // pull-up bits, top bit pull-down
  input wire logic [NUM_IO-1:0] drive,          // output value per i/o pin
  input wire logic [NUM_IO:0] pad_di,           // pad receiver levels
  input wire logic wake_read_en,                // lets the wake pin reach its buffer
  output logic [NUM_IO-1:0] pad_do,             // pad output values
  output logic [NUM_IO-1:0] pad_oe_b,           // low while driving
  output logic [NUM_IO:0] pin_in_en,            // input receiver connected
  output logic [NUM_IO-1:0] pullup_on,          // pull-up enables
  output logic pin3_pulldown_on,                // pull-down on the wake pin
  output logic [NUM_IO:0] buf_level             // level seen at each buffer
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // the wake pin sits above the i/o pins, so at least one i/o pin is needed
  if (NUM_IO < 1) begin : g_bad_num_io
    $error("NUM_IO must be at least 1");
  end

  // ----------------------------------------------------------------
  // bidirectional pins
  // ----------------------------------------------------------------
  // the logic behind each pin keeps running; conn only couples the pad
  for (genvar i = 0; i < NUM_IO; i++) begin : g_io
    // R3 direction selects driver
    assign pad_oe_b[i] = ~(conn[i] & dir[i]);
    assign pad_do[i] = drive[i];
    // R4 disabled pin floats
    assign pin_in_en[i] = conn[i];
    // R9 pull-up per pin
    assign pullup_on[i] = pull[i];
    assign buf_level[i] = pad_di[i] & conn[i];
  end

  // ----------------------------------------------------------------
  // input-only wake pin
  // ----------------------------------------------------------------
  // R5 input only when connected
  assign pin_in_en[NUM_IO] = conn[NUM_IO];
  // R8 pull-down on wake pin
  assign pin3_pulldown_on = pull[NUM_IO];
  // high-voltage input stage reaches the buffer only when enabled
  assign buf_level[NUM_IO] = pad_di[NUM_IO] & conn[NUM_IO] & wake_read_en;

endmodule

// ==== gpc_pkg.sv ====
// shared constants for the four-pin port configuration block
package gpc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = base + 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTL = 8'h40;
  localparam logic [7:0] IDX_PULL = 8'h42;
  localparam logic [7:0] IDX_LEVEL = 8'h43;
  localparam logic [7:0] IDX_ROUTE0 = 8'h44;

  // ----------------------------------------------------------------
  // window bases in the global address space
  // ----------------------------------------------------------------
  localparam logic [15:0] BASE_BLOCKING = 16'h0200;
  localparam logic [15:0] BASE_NONBLOCKING = 16'h0300;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_CONN_LSB = 0;
  localparam int CTL_DIR_LSB = 4;
  localparam int CTL_CONN_MASK_LSB = 8;
  localparam int CTL_DIR_MASK_LSB = 12;
  localparam int PULL_LSB = 0;
  localparam int ROUTE_BUS_POS = 1;
  localparam int ROUTE_SER_POS = 2;
  localparam int ROUTE_CAP_LSB = 3;

  // ----------------------------------------------------------------
  // reset values and bus codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [7:0] ROUTE0_RST = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// ==== gpc_port_cfg.sv ====
// top of the four-pin port configuration block with its AHB-Lite slave
// What this block does
// R1 - A direction bit changes on a control write only when its direction mask bit in that write is one.
// R2 - A pin connect bit changes on a control write only when its connect mask bit in that write is one.
// R3 - Direction bits 6, 5, 4 make pins 2, 1, 0 inputs when zero and outputs when one.
// R4 - Connect bits 2, 1, 0 leave pins 2, 1, 0 floating when zero and couple them for input/output when one.
// R5 - Connect bit 3 leaves pin 3 floating when zero and couples it as an input only when one.
// R6 - The port logic runs whatever the connect bits say; they only couple it to the pad buffers.
// R7 - Software touches the control register only as a 16-bit word, never by byte.
// R8 - Pull bit 3 switches the pin 3 pull-down on when one and off when zero.
// R9 - Pull bits 2, 1, 0 switch the pull-ups of pins 2, 1, 0 on when one and off when zero.
// R10 - The level register returns in bits 3 to 0 the buffer values of pins 3 to 0 and ignores writes.
// R11 - Software sets the high-voltage wake read enable before reading the pin 3 level in normal mode.
// R12 - Routing bits 6 to 3 couple the pin 0 buffer to capture channels 3 to 0 when one.
// R13 - Routing bit 2 couples the pin 0 buffer to the serial receive input when one.
// R14 - Routing bit 1 couples the pin 0 buffer to the bus transmit input when one.
// R15 - Registers decode relative to base 0x0200 for blocking and 0x300 for non-blocking access.
// R16 - Mask, unused and reserved bits read as zero and writes to unused bits are dropped.
// R17 - After reset every direction, connect, pull and routing bit is zero.
//
// Added by the designer: register access over AHB-Lite.
module gpc_port_cfg #(
  parameter int ADDR_W = 16
) (
  input wire logic ref_clk,                       // system clock
  input wire logic rst_b,                         // async reset, active low
  input wire logic hsel,                          // slave select
  input wire logic [ADDR_W-1:0] haddr,            // byte address
  input wire logic [1:0] htrans,                  // transfer type
  input wire logic hwrite,                        // 1 = write
  input wire logic [2:0] hsize,                   // word only
  input wire logic [31:0] hwdata,                 // write data
  input wire logic hready,                        // bus ready
  output logic hreadyout,                         // never stalls
  output logic [31:0] hrdata,                     // read data
  output logic hresp,                             // always okay
  input wire logic [2:0] pin_drive,               // output values for pins 0..2
  input wire logic [3:0] pad_di,                  // pad levels, pins 0..3
  input wire logic high_voltage_wake_read_enable, // from pin 3 routing logic
  output logic [2:0] pad_do,                      // pad output values
  output logic [2:0] pad_oe_b,                    // low while driving
  output logic [3:0] pin_in_en,                   // input receivers coupled
  output logic [2:0] pullup_on,                   // pull-ups pins 0..2
  output logic pin3_pulldown_on,                  // pull-down pin 3
  output logic [3:0] route_to_capture,            // capture channels 3..0
  output logic route_to_serial_receive,           // serial receive input
  output logic route_to_bus_transmit              // bus transmit input
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // both windows together span up to 0x6FF
  if (ADDR_W < 11) begin : g_bad_addr_w
    $error("ADDR_W too small for the register windows");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_sync_b;

  // two-stage release, assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] dir;
    logic [3:0] conn;
    logic [3:0] pull;
    logic [3:0] cap;
    logic ser;
    logic bus;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
  } gpc_state_s;

  localparam gpc_state_s ST_RST = '{
    dir: gpc_pkg::CTL_RST[6:4],
    conn: gpc_pkg::CTL_RST[3:0],
    pull: gpc_pkg::PULL_RST[3:0],
    cap: gpc_pkg::ROUTE0_RST[6:3],
    ser: gpc_pkg::ROUTE0_RST[2],
    bus: gpc_pkg::ROUTE0_RST[1],
    wr_pend: 1'b0,
    wr_idx: 8'h00,
    rdata: 32'h0000_0000
  };

  gpc_state_s st_ff;
  gpc_state_s nxt_st;
  logic [3:0] buf_level;
  logic acc;
  logic dec_hit;
  logic [7:0] dec_idx;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_reg(input logic [7:0] idx);
    return (idx == gpc_pkg::IDX_CTL) || (idx == gpc_pkg::IDX_PULL) ||
           (idx == gpc_pkg::IDX_LEVEL) || (idx == gpc_pkg::IDX_ROUTE0);
  endfunction

  // returns {hit, index}; the two windows never claim the same address
  function automatic logic [8:0] decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rb;
    logic [ADDR_W-1:0] rn;
    logic hb;
    logic hn;
    rb = a - ADDR_W'(gpc_pkg::BASE_BLOCKING);
    rn = a - ADDR_W'(gpc_pkg::BASE_NONBLOCKING);
    hb = (rb[ADDR_W-1:gpc_pkg::IDX_MSB+1] == '0) && (rb[1:0] == 2'h0) &&
         is_reg(rb[gpc_pkg::IDX_MSB:gpc_pkg::IDX_LSB]);
    hn = (rn[ADDR_W-1:gpc_pkg::IDX_MSB+1] == '0) && (rn[1:0] == 2'h0) &&
         is_reg(rn[gpc_pkg::IDX_MSB:gpc_pkg::IDX_LSB]);
    if (hb) begin
      return {1'b1, rb[gpc_pkg::IDX_MSB:gpc_pkg::IDX_LSB]};
    end else if (hn) begin
      return {1'b1, rn[gpc_pkg::IDX_MSB:gpc_pkg::IDX_LSB]};
    end
    return 9'h000;
  endfunction

  // R15 both windows decoded
  assign {dec_hit, dec_idx} = decode(haddr);
  assign acc = hsel && (htrans == gpc_pkg::HTRANS_NONSEQ) && hready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // writes land in the data phase; a read in the same cycle sees them
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.wr_pend) begin
      case (st_ff.wr_idx)
        gpc_pkg::IDX_CTL: begin
          // R7 one 16-bit word carries data and masks
          for (int i = 0; i < 3; i++) begin
            // R1 masked direction update
            if (hwdata[gpc_pkg::CTL_DIR_MASK_LSB+i]) begin
              nxt_st.dir[i] = hwdata[gpc_pkg::CTL_DIR_LSB+i];
            end
          end
          for (int i = 0; i < 4; i++) begin
            // R2 masked connect update
            if (hwdata[gpc_pkg::CTL_CONN_MASK_LSB+i]) begin
              nxt_st.conn[i] = hwdata[gpc_pkg::CTL_CONN_LSB+i];
            end
          end
        end
        gpc_pkg::IDX_PULL: begin
          // R16 upper bits dropped
          nxt_st.pull = hwdata[gpc_pkg::PULL_LSB+:4];
        end
        gpc_pkg::IDX_ROUTE0: begin
          nxt_st.cap = hwdata[gpc_pkg::ROUTE_CAP_LSB+:4];
          nxt_st.ser = hwdata[gpc_pkg::ROUTE_SER_POS];
          nxt_st.bus = hwdata[gpc_pkg::ROUTE_BUS_POS];
        end
        // R10 level register ignores writes
        default: begin
        end
      endcase
    end
    nxt_st.wr_pend = acc && hwrite && dec_hit;
    nxt_st.wr_idx = dec_idx;
    // R16 masks, unused bits and unmapped addresses read zero
    nxt_st.rdata = 32'h0000_0000;
    if (acc && !hwrite && dec_hit) begin
      case (dec_idx)
        gpc_pkg::IDX_CTL: nxt_st.rdata = {25'h0000000, nxt_st.dir, nxt_st.conn};
        gpc_pkg::IDX_PULL: nxt_st.rdata = {28'h0000000, nxt_st.pull};
        // R10 live buffer levels
        gpc_pkg::IDX_LEVEL: nxt_st.rdata = {28'h0000000, buf_level};
        gpc_pkg::IDX_ROUTE0: nxt_st.rdata = {25'h0000000, nxt_st.cap, nxt_st.ser, nxt_st.bus, 1'b0};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // R17 everything cleared at reset
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // zero wait states, so the slave never holds the bus
  assign hreadyout = 1'b1;
  assign hresp = gpc_pkg::HRESP_OKAY;
  assign hrdata = st_ff.rdata;

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  // R6 logic live, pads coupled by conn
  gpc_pad_ctl #(
    .NUM_IO(3)
  ) gpc_pad_ctl_inst (
    .dir(st_ff.dir),
    .conn(st_ff.conn),
    .pull(st_ff.pull),
    .drive(pin_drive),
    .pad_di(pad_di),
    .wake_read_en(high_voltage_wake_read_enable),
    .pad_do(pad_do),
    .pad_oe_b(pad_oe_b),
    .pin_in_en(pin_in_en),
    .pullup_on(pullup_on),
    .pin3_pulldown_on(pin3_pulldown_on),
    .buf_level(buf_level)
  );

  // ----------------------------------------------------------------
  // pin 0 input routing
  // ----------------------------------------------------------------
  // R12 capture channel routing
  assign route_to_capture = {4{buf_level[0]}} & st_ff.cap;
  // R13 serial receive routing
  assign route_to_serial_receive = buf_level[0] & st_ff.ser;
  // R14 bus transmit routing
  assign route_to_bus_transmit = buf_level[0] & st_ff.bus;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync_b);

  sequence s_ctl_wr;
    st_ff.wr_pend && (st_ff.wr_idx == gpc_pkg::IDX_CTL);
  endsequence

  sequence s_pull_wr;
    st_ff.wr_pend && (st_ff.wr_idx == gpc_pkg::IDX_PULL);
  endsequence

  sequence s_route_wr;
    st_ff.wr_pend && (st_ff.wr_idx == gpc_pkg::IDX_ROUTE0);
  endsequence

  sequence s_level_wr;
    st_ff.wr_pend && (st_ff.wr_idx == gpc_pkg::IDX_LEVEL);
  endsequence

  AST_DIR_HOLD: assert property (s_ctl_wr ##0 !hwdata[12] |=> st_ff.dir[0] == $past(st_ff.dir[0])) // R1
    else $error("direction changed without its mask");
  AST_DIR_LOAD: assert property (s_ctl_wr ##0 hwdata[14] |=> st_ff.dir[2] == $past(hwdata[6])) // R1
    else $error("masked direction write not taken");
  AST_CONN_HOLD: assert property (s_ctl_wr ##0 !hwdata[11] |=> st_ff.conn[3] == $past(st_ff.conn[3])) // R2
    else $error("connect changed without its mask");
  // a masked connect write must land, not only be refused
  AST_CONN_LOAD: assert property (s_ctl_wr ##0 hwdata[8] |=> st_ff.conn[0] == $past(hwdata[0])) // R2
    else $error("masked connect write not taken");
  AST_DRIVE_ON: assert property (s_ctl_wr ##0 (hwdata[13] && hwdata[5] && hwdata[9] && hwdata[1]) // R3
    |=> !pad_oe_b[1])
    else $error("pin 1 not driving after output select");
  AST_FLOAT: assert property (s_ctl_wr ##0 (hwdata[8] && !hwdata[0]) |=> pad_oe_b[0] && !pin_in_en[0]) // R4
    else $error("pin 0 still coupled after disconnect");
  AST_PIN3_IN: assert property (s_ctl_wr ##0 (hwdata[11] && hwdata[3]) |=> pin_in_en[3]) // R5
    else $error("pin 3 input not coupled");
  AST_PULL: assert property (s_pull_wr |=> (pullup_on == $past(hwdata[2:0])) && // R8 R9
    (pin3_pulldown_on == $past(hwdata[3])))
    else $error("pull outputs do not follow write");
  AST_LEVEL: assert property (acc && !hwrite && dec_hit && (dec_idx == gpc_pkg::IDX_LEVEL) // R10
    |=> hrdata == {28'h0000000, $past(buf_level)})
    else $error("level read wrong");
  // a write to the level register leaves the direction, connect, pull and capture bits alone
  AST_LEVEL_RO: assert property (s_level_wr |=> (st_ff.dir == $past(st_ff.dir)) && // R10
    (st_ff.conn == $past(st_ff.conn)) && (st_ff.pull == $past(st_ff.pull)) && (st_ff.cap == $past(st_ff.cap)))
    else $error("level register write changed state");
  AST_ROUTE: assert property (s_route_wr ##0 hwdata[6] ##1 (pad_di[0] && st_ff.conn[0]) // R12
    |-> route_to_capture[3])
    else $error("capture channel 3 not routed");
  AST_SER_ROUTE: assert property (s_route_wr ##0 hwdata[2] ##1 (pad_di[0] && st_ff.conn[0]) // R13
    |-> route_to_serial_receive)
    else $error("serial receive not routed");
  AST_BUS_ROUTE: assert property (s_route_wr ##0 hwdata[1] ##1 (pad_di[0] && st_ff.conn[0]) // R14
    |-> route_to_bus_transmit)
    else $error("bus transmit not routed");
  // a low pin 0 buffer must never reach a routed input as a high
  AST_ROUTE_LOW: assert property (!pad_di[0] |-> (route_to_capture == 4'h0) && // R12
    !route_to_serial_receive && !route_to_bus_transmit)
    else $error("routed input high while pin 0 low");
  AST_UNMAPPED: assert property (acc && !hwrite && !dec_hit |=> hrdata == 32'h0000_0000) // R16
    else $error("unmapped read not zero");
  AST_RESET: assert property ($rose(rst_sync_b) |-> (st_ff.dir == 3'h0) && (st_ff.conn == 4'h0) && // R17
    (st_ff.pull == 4'h0) && (st_ff.cap == 4'h0) && !st_ff.ser && !st_ff.bus)
    else $error("state not cleared by reset");

endmodule

// ==== gpio_port_config_tb.sv ====
// self-checking bench for the four-pin port configuration block
module gpio_port_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and row table
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [2:0] oe_b;
    logic [3:0] in_en;
  } gpc_row_s;

  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [2:0] pin_drive = 3'h0;
  logic [3:0] pad_di = 4'h0;
  logic wake_en = 1'b0;
  logic [2:0] pad_do;
  logic [2:0] pad_oe_b;
  logic [3:0] pin_in_en;
  logic [2:0] pullup_on;
  logic pin3_pulldown_on;
  logic [3:0] route_to_capture;
  logic route_to_serial_receive;
  logic route_to_bus_transmit;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] q;
  // masked control walk, then pull, routing, alias window, unmapped and level rows
  gpc_row_s rows [13] = '{
    '{16'h0300, 32'h00007F7F, 32'h0000007F, 3'h0, 4'hF},
    '{16'h0300, 32'h00000000, 32'h0000007F, 3'h0, 4'hF},
    '{16'h0300, 32'h00001000, 32'h0000006F, 3'h1, 4'hF},
    '{16'h0300, 32'h00000100, 32'h0000006E, 3'h1, 4'hE},
    '{16'h0300, 32'h00000F00, 32'h00000060, 3'h7, 4'h0},
    '{16'h0300, 32'h00007F70, 32'h00000070, 3'h7, 4'h0},
    '{16'h0300, 32'h00000F0F, 32'h0000007F, 3'h0, 4'hF},
    '{16'h0308, 32'hFFFFFFFF, 32'h0000000F, 3'h0, 4'hF},
    '{16'h0310, 32'hFFFFFFFF, 32'h0000007E, 3'h0, 4'hF},
    '{16'h0408, 32'h00000005, 32'h00000005, 3'h0, 4'hF},
    '{16'h0410, 32'h0000000A, 32'h0000000A, 3'h0, 4'hF},
    '{16'h0314, 32'h000000FF, 32'h00000000, 3'h0, 4'hF},
    '{16'h030C, 32'h0000000F, 32'h00000000, 3'h0, 4'hF}
  };

  gpc_port_cfg #(.ADDR_W(16)) gpc_port_cfg_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pin_drive(pin_drive), .pad_di(pad_di),
    .high_voltage_wake_read_enable(wake_en), .pad_do(pad_do), .pad_oe_b(pad_oe_b),
    .pin_in_en(pin_in_en), .pullup_on(pullup_on), .pin3_pulldown_on(pin3_pulldown_on),
    .route_to_capture(route_to_capture), .route_to_serial_receive(route_to_serial_receive),
    .route_to_bus_transmit(route_to_bus_transmit)
  );

  // ----------------------------------------------------------------
  // clock, tasks
  // ----------------------------------------------------------------
  // 125 MHz system clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single AHB transfer; entered just after a rising edge, returns just after one
  task automatic ahb_xfer(input logic [15:0] a, input logic wr, input logic [31:0] d,
                          output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= gpc_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    // address phase stands until hready is seen high at a rising edge
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    // data phase: read data and response taken at the edge that ends it
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, {31'h0, gpc_pkg::HRESP_OKAY});
    // released data lines must not keep the last value
    hwdata <= ~d;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] unused;
    ahb_xfer(a, 1'b1, d, unused);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    ahb_xfer(a, 1'b0, 32'h0, v);
  endtask

  // checks taken at the next falling edge after the caller returns
  task automatic check_cfg(input logic [2:0] oe, input logic [3:0] ien);
    @(negedge ref_clk);
    check("pad_oe_b", {29'h0, pad_oe_b}, {29'h0, oe});
    check("pin_in_en", {28'h0, pin_in_en}, {28'h0, ien});
    @(posedge ref_clk);
  endtask

  task automatic check_reset();
    check("pad_oe_b", {29'h0, pad_oe_b}, 32'h7);
    check("pins", {20'h0, pin_in_en, pullup_on, pin3_pulldown_on, route_to_capture}, 32'h0);
    check("routes", {30'h0, route_to_serial_receive, route_to_bus_transmit}, 32'h0);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the roughly 135 cycles the tests take
  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (9) @(posedge ref_clk);
    @(negedge ref_clk);
    check_reset();
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    $display("test reset done");
    // table rows: write, read back, pad steering
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, q);
      check("row readback", q, rows[i].rdata);
      check_cfg(rows[i].oe_b, rows[i].in_en);
    end
    $display("test table done");
    // pull-ups and pull-down driven from the pull bits
    wr(16'h0308, 32'h00000005);
    check_cfg(3'h0, 4'hF);
    check("pulls", {28'h0, pullup_on, pin3_pulldown_on}, 32'hA);
    wr(16'h0408, 32'h00000008);
    check_cfg(3'h0, 4'hF);
    check("pulls", {28'h0, pullup_on, pin3_pulldown_on}, 32'h1);
    $display("test pulls done");
    // level readback: wake pin needs its read enable, pin 1 its connect
    pad_di <= 4'hF;
    pin_drive <= 3'h5;
    rd(16'h030C, q);
    check("level", q, 32'h7);
    wake_en <= 1'b1;
    rd(16'h030C, q);
    check("level", q, 32'hF);
    wr(16'h0300, 32'h00000200);
    rd(16'h040C, q);
    check("level", q, 32'hD);
    // port logic keeps working with the pin disconnected
    check("pad_do", {29'h0, pad_do}, 32'h5);
    wr(16'h0300, 32'h00000F00);
    check_cfg(3'h7, 4'h0);
    check("pad_do", {29'h0, pad_do}, 32'h5);
    wr(16'h0300, 32'h00000F0F);
    $display("test level done");
    // one routing bit at a time toward the pin 0 buffer
    for (int b = 1; b < 7; b++) begin
      wr(16'h0310, 32'h1 << b);
      @(negedge ref_clk);
      check("capture", {28'h0, route_to_capture}, (b >= 3) ? (32'h1 << (b - 3)) : 32'h0);
      check("serial", {31'h0, route_to_serial_receive}, {31'h0, b == 2});
      check("bus tx", {31'h0, route_to_bus_transmit}, {31'h0, b == 1});
      @(posedge ref_clk);
      pad_di <= 4'hE;
      @(negedge ref_clk);
      check("routes low", {26'h0, route_to_capture, route_to_serial_receive, route_to_bus_transmit},
            32'h0);
      @(posedge ref_clk);
      pad_di <= 4'hF;
    end
    $display("test routing done");
    // second reset in mid-run clears everything
    wr(16'h0310, 32'h0000007E);
    rst_b <= 1'b0;
    @(negedge ref_clk);
    check_reset();
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(16'h0300, q);
    check("ctl after reset", q, 32'h0);
    rd(16'h0308, q);
    check("pull after reset", q, 32'h0);
    rd(16'h0310, q);
    check("route after reset", q, 32'h0);
    $display("test second reset done");
    summarize();
  end
endmodule
